/* File: src/rtc_pkg.sv */
// Register map, field positions, reset values and timing counts of the RTC.
package rtc_pkg;
  localparam logic [7:0] RTC_OFF_INTEN = 8'h00;
  localparam logic [7:0] RTC_OFF_CTL   = 8'h04;
  localparam logic [7:0] RTC_OFF_PSCH  = 8'h08;
  localparam logic [7:0] RTC_OFF_PSCL  = 8'h0c;
  localparam logic [7:0] RTC_OFF_DIVH  = 8'h10;
  localparam logic [7:0] RTC_OFF_DIVL  = 8'h14;
  localparam logic [7:0] RTC_OFF_CNTH  = 8'h18;
  localparam logic [7:0] RTC_OFF_CNTL  = 8'h1c;
  localparam logic [7:0] RTC_OFF_ALRMH = 8'h20;
  localparam logic [7:0] RTC_OFF_ALRML = 8'h24;

  localparam int RTC_BIT_SEC   = 0;
  localparam int RTC_BIT_ALARM = 1;
  localparam int RTC_BIT_OVF   = 2;
  localparam int RTC_BIT_SYNC  = 3;
  localparam int RTC_BIT_CFG   = 4;
  localparam int RTC_BIT_WDONE = 5;

  localparam logic [2:0]  INTERRUPT_ENABLE_RST = 3'h0;
  localparam logic [19:0] PRESCALER_RELOAD_RST   = 20'h08000;
  localparam logic [19:0] RTC_DIV_RST   = 20'h08000;
  localparam logic [31:0] TIME_COUNTER_RST   = 32'h00000000;
  localparam logic [31:0] ALARM_VALUE_RST  = 32'hffffffff;

  localparam logic [1:0] RTC_XFER_TK_CYCLES = 2'h3;
  localparam logic [5:0] RTC_HSX_HALF_DIV   = 6'h3f;

  typedef enum logic [1:0] {
    RTC_SRC_NONE  = 2'b00,
    RTC_SRC_LSX   = 2'b01,
    RTC_SRC_IRC   = 2'b10,
    RTC_SRC_HSX   = 2'b11
  } rtc_src_t;

  typedef enum logic [0:0] {
    RTC_XFER_IDLE = 1'b0,
    RTC_XFER_BUSY = 1'b1
  } rtc_xfer_t;
endpackage

/* File: src/rtc_core.sv */
// Real-time clock: APB register interface, prescaler, counter and alarm.
//
// Function
// - 32-bit up-counter advances every seconds tick.
// - 20-bit divider makes seconds tick.
// - Timekeeping source selectable among three oscillators.
// - Second interrupt on every seconds tick.
// - Alarm interrupt when counter equals alarm.
// - System reset interface; backup reset core.
// - Core settings survive system reset and standby.
// - Counter, divider, flags update each timekeeping edge.
// - Synced flag set after first update.
// - Processor sleep leaves interface untouched.
// - Core registers writable only in configuration mode.
// - Buffered writes apply after three timekeeping cycles.
// - Write-done flag set when core write completes.
// - Second flag on last cycle before update.
// - Alarm flag before alarm-valued counter increments.
// - Overflow flag before counter wraps to zero.
// - Enable bits: overflow 2, alarm 1, second 0.
// - Tick rate is source over reload plus one.
// - Divider reload sets second flag, increments counter.
// - Overflow flag with enable requests interrupt.
`timescale 1ns/1ns
module rtc_core
  import rtc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        bkp_rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        high_speed_crystal,
  input  wire logic        low_speed_crystal,
  input  wire logic        internal_40k_oscillator,
  input  wire logic [1:0]  clk_src_sel,
  output logic             irq
);
  logic        hx_prev;
  logic [5:0]  hx_cnt;
  logic        hx_div;
  logic        tk_prev;
  logic [19:0] psc;
  logic [19:0] div;
  logic [31:0] cnt;
  logic [31:0] alrm;
  logic        second_flag;
  logic        alarm_flag;
  logic        overflow_flag;
  logic [2:0]  interrupt_enable;
  logic        config_mode_flag;
  logic        regs_synced_flag;
  logic        write_done_flag;
  rtc_xfer_t   xfer_state;
  logic [1:0]  xfer_cnt;
  logic [19:0] sh_psc;
  logic [31:0] sh_cnt;
  logic [31:0] sh_alrm;
  logic [2:0]  pend;
  logic [19:0] snap_div;
  logic [31:0] snap_cnt;

  // The source oscillators arrive as levels sampled on ref_clk, so the
  // timekeeping clock becomes a one-cycle edge strobe, not a second domain.
  // This is why it must run well below the bus clock.
  wire hx_rise = high_speed_crystal & ~hx_prev;
  wire tk_src  = (clk_src_sel == RTC_SRC_LSX) ? low_speed_crystal :
                 (clk_src_sel == RTC_SRC_IRC) ? internal_40k_oscillator :
                 (clk_src_sel == RTC_SRC_HSX) ? hx_div : 1'b0;
  wire tk_rise = tk_src & ~tk_prev;
  wire reload  = tk_rise & (div == 20'h00000);
  wire xfer_end = (xfer_state == RTC_XFER_BUSY) & tk_rise &
                  (xfer_cnt == RTC_XFER_TK_CYCLES - 2'h1);

  wire wr = psel & penable & pwrite;
  wire wr_ctl = wr & (paddr == RTC_OFF_CTL);
  wire core_wr_ok = wr & config_mode_flag &
                    (xfer_state == RTC_XFER_IDLE);
  wire cfg_exit = wr_ctl & config_mode_flag & ~pwdata[RTC_BIT_CFG];

  wire set_sec = reload;
  wire set_alm = reload & (cnt == alrm);
  wire set_ovf = reload & (cnt == 32'hffffffff);

  wire [19:0] next_div = (xfer_end & pend[0]) ? sh_psc :
                         reload ? psc :
                         tk_rise ? div - 20'h00001 : div;
  wire [31:0] next_cnt = (xfer_end & pend[1]) ? sh_cnt :
                         reload ? cnt + 32'h00000001 : cnt;

  wire addr_ok = (paddr <= RTC_OFF_ALRML) & (paddr[1:0] == 2'b00);
  wire [31:0] ctl_val = {26'h0, write_done_flag, config_mode_flag,
                         regs_synced_flag, overflow_flag, alarm_flag,
                         second_flag};
  // Only counter and divider are readable from the core.
  wire [31:0] rd_data =
    (paddr == RTC_OFF_INTEN) ? {29'h0, interrupt_enable} :
    (paddr == RTC_OFF_CTL)   ? ctl_val :
    (paddr == RTC_OFF_DIVH)  ? {28'h0, snap_div[19:16]} :
    (paddr == RTC_OFF_DIVL)  ? {16'h0, snap_div[15:0]} :
    (paddr == RTC_OFF_CNTH)  ? {16'h0, snap_cnt[31:16]} :
    (paddr == RTC_OFF_CNTL)  ? {16'h0, snap_cnt[15:0]} : 32'h0;

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;

  // Processor sleep has no input here, so the interface keeps its state.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= rd_data;
    end
  end

  // Backup domain: survives system reset and standby.
  always_ff @(posedge ref_clk or negedge bkp_rst_n) begin
    if (!bkp_rst_n) begin
      hx_prev <= 1'b0;
      hx_cnt  <= 6'h00;
      hx_div  <= 1'b0;
      tk_prev <= 1'b0;
      psc     <= PRESCALER_RELOAD_RST;
      div     <= RTC_DIV_RST;
      cnt     <= TIME_COUNTER_RST;
      alrm    <= ALARM_VALUE_RST;
    end else begin
      hx_prev <= high_speed_crystal;
      if (hx_rise) begin
        hx_cnt <= hx_cnt + 6'h01;
        if (hx_cnt == RTC_HSX_HALF_DIV) begin
          hx_div <= ~hx_div;
        end
      end
      tk_prev <= tk_src;
      div     <= next_div;
      cnt     <= next_cnt;
      if (xfer_end & pend[0]) begin
        psc <= sh_psc;
      end
      if (xfer_end & pend[2]) begin
        alrm <= sh_alrm;
      end
    end
  end

  // Flags live with the core; a set in the clearing cycle wins.
  always_ff @(posedge ref_clk or negedge bkp_rst_n) begin
    if (!bkp_rst_n) begin
      second_flag   <= 1'b0;
      alarm_flag    <= 1'b0;
      overflow_flag <= 1'b0;
    end else begin
      second_flag   <= set_sec |
        (second_flag & ~(wr_ctl & ~pwdata[RTC_BIT_SEC]));
      alarm_flag    <= set_alm |
        (alarm_flag & ~(wr_ctl & ~pwdata[RTC_BIT_ALARM]));
      overflow_flag <= set_ovf |
        (overflow_flag & ~(wr_ctl & ~pwdata[RTC_BIT_OVF]));
    end
  end

  // Interface domain, cleared by system reset.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      interrupt_enable <= INTERRUPT_ENABLE_RST;
      config_mode_flag <= 1'b0;
      regs_synced_flag <= 1'b0;
      snap_div         <= 20'h00000;
      snap_cnt         <= 32'h00000000;
    end else begin
      if (wr & (paddr == RTC_OFF_INTEN)) begin
        interrupt_enable <= pwdata[2:0];
      end
      if (wr_ctl) begin
        config_mode_flag <= pwdata[RTC_BIT_CFG];
      end
      regs_synced_flag <= tk_rise |
        (regs_synced_flag & ~(wr_ctl & ~pwdata[RTC_BIT_SYNC]));
      if (tk_rise) begin
        snap_div <= next_div;
        snap_cnt <= next_cnt;
      end
    end
  end

  // Writes wait in shadows until configuration mode is left.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sh_psc  <= 20'h00000;
      sh_cnt  <= 32'h00000000;
      sh_alrm <= 32'h00000000;
      pend    <= 3'h0;
    end else begin
      if (core_wr_ok & (paddr == RTC_OFF_PSCH)) begin
        sh_psc[19:16] <= pwdata[3:0];
      end
      if (core_wr_ok & (paddr == RTC_OFF_PSCL)) begin
        sh_psc[15:0] <= pwdata[15:0];
      end
      if (core_wr_ok & (paddr == RTC_OFF_CNTH)) begin
        sh_cnt[31:16] <= pwdata[15:0];
      end
      if (core_wr_ok & (paddr == RTC_OFF_CNTL)) begin
        sh_cnt[15:0] <= pwdata[15:0];
      end
      if (core_wr_ok & (paddr == RTC_OFF_ALRMH)) begin
        sh_alrm[31:16] <= pwdata[15:0];
      end
      if (core_wr_ok & (paddr == RTC_OFF_ALRML)) begin
        sh_alrm[15:0] <= pwdata[15:0];
      end
      if (xfer_end) begin
        pend <= 3'h0;
      end else if (core_wr_ok) begin
        pend <= pend | {(paddr == RTC_OFF_ALRMH) | (paddr == RTC_OFF_ALRML),
                        (paddr == RTC_OFF_CNTH) | (paddr == RTC_OFF_CNTL),
                        (paddr == RTC_OFF_PSCH) | (paddr == RTC_OFF_PSCL)};
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      xfer_state      <= RTC_XFER_IDLE;
      xfer_cnt        <= 2'h0;
      write_done_flag <= 1'b1;
    end else begin
      case (xfer_state)
        RTC_XFER_IDLE: begin
          if (cfg_exit & (pend != 3'h0)) begin
            xfer_state      <= RTC_XFER_BUSY;
            xfer_cnt        <= 2'h0;
            write_done_flag <= 1'b0;
          end
        end
        RTC_XFER_BUSY: begin
          if (xfer_end) begin
            xfer_state      <= RTC_XFER_IDLE;
            write_done_flag <= 1'b1;
          end else if (tk_rise) begin
            xfer_cnt <= xfer_cnt + 2'h1;
          end
        end
        default: begin
          xfer_state <= RTC_XFER_IDLE;
        end
      endcase
    end
  end

  // Registered so that a glitch on the flag logic never reaches the
  // interrupt controller.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= (second_flag & interrupt_enable[RTC_BIT_SEC]) |
             (alarm_flag & interrupt_enable[RTC_BIT_ALARM]) |
             (overflow_flag & interrupt_enable[RTC_BIT_OVF]);
    end
  end
endmodule // rtc_core

/* File: tb/rtc_props.sv */
// Port checker for the real-time clock core.
`timescale 1ns/1ns
module rtc_props
  import rtc_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        bkp_rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        high_speed_crystal,
  input wire logic        low_speed_crystal,
  input wire logic        internal_40k_oscillator,
  input wire logic [1:0]  clk_src_sel,
  input wire logic        irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire bad = (paddr > RTC_OFF_ALRML) || (paddr[1:0] != 2'h0);
  wire rda = psel && penable && !pwrite;
  wire rds = psel && !penable && !pwrite;
  sequence s_mask_all;
    psel && penable && pwrite && paddr == RTC_OFF_INTEN &&
      pwdata[2:0] == 3'h0;
  endsequence
  // The enable lands one edge before the registered output follows it.
  sequence s_quiet;
    ##1 !irq [*2];
  endsequence
  a_ready_high: assert property (pready)
    else $error("pready dropped");
  a_err_match: assert property (psel && penable |-> pslverr == bad)
    else $error("pslverr does not match address decode");
  a_rdata_holds: assert property (
    !$past(rds) |-> $stable(prdata))
    else $error("prdata changed outside a read");
  a_inten_width: assert property (
    rda && paddr == RTC_OFF_INTEN |-> prdata[31:3] == 29'h0)
    else $error("enable register reserved bits set");
  a_ctl_width: assert property (
    rda && paddr == RTC_OFF_CTL |-> prdata[31:6] == 26'h0)
    else $error("control reserved bits set");
  a_psc_unread: assert property (
    rda && paddr == RTC_OFF_PSCL |-> prdata == 32'h0)
    else $error("prescaler reload readable");
  a_div_width: assert property (
    rda && paddr == RTC_OFF_DIVH |-> prdata[31:4] == 28'h0)
    else $error("divider high wider than four bits");
  a_irq_masked: assert property (s_mask_all |=> s_quiet)
    else $error("irq high with all enables off");
endmodule // rtc_props

bind rtc_core rtc_props i_rtc_props (.ref_clk(ref_clk), .rst_n(rst_n),
  .bkp_rst_n(bkp_rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .high_speed_crystal(high_speed_crystal),
  .low_speed_crystal(low_speed_crystal), .clk_src_sel(clk_src_sel),
  .internal_40k_oscillator(internal_40k_oscillator), .irq(irq));

/* File: tb/rtc_osc_model.sv */
// Slow oscillator model feeding the timekeeping source inputs.
`timescale 1ns/1ns
module rtc_osc_model (
  input  wire logic ref_clk,
  output logic      osc
);
  initial osc = 1'b0;
  // Each level lasts four bus clocks, so the source stays eight times
  // slower; between bursts it stands still for exact tick counts.
  task automatic pulses(input int n);
    repeat (n) begin
      repeat (4) @(posedge ref_clk);
      #1 osc = 1'b1;
      repeat (4) @(posedge ref_clk);
      #1 osc = 1'b0;
    end
  endtask
endmodule // rtc_osc_model

/* File: tb/rtc_core_test.sv */
// Self-checking bench for the real-time clock core.
`timescale 1ns/1ns
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module rtc_core_test
  import rtc_pkg::*;
;
  logic        ref_clk = 1'b0, rst_n = 1'b0, bkp_n = 1'b0, osc, err;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, hsx = 1'b0;
  logic        pready, pslverr, irq;
  logic [1:0]  sel = 2'h1;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, v;
  int          failures = 0, n_compared = 0, seed = 71;
  int          m_cnt = 0, m_div = 32'h8000, m_psc = 32'h8000;
  rtc_osc_model i_rtc_osc_model (.ref_clk(ref_clk), .osc(osc));
  rtc_core i_rtc_core (.ref_clk(ref_clk), .rst_n(rst_n), .bkp_rst_n(bkp_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .high_speed_crystal(hsx), .low_speed_crystal(osc),
    .internal_40k_oscillator(osc), .clk_src_sel(sel), .irq(irq));
  initial forever #25 ref_clk = ~ref_clk;
  task automatic finish_test;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge ref_clk) #1 {psel, pwrite, paddr, pwdata} = {1'b1, w, a, d};
    @(posedge ref_clk) #1 penable = 1'b1;
    for (i = 0; i < 9; i++) begin
      @(posedge ref_clk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    if (i == 9) begin failures++; finish_test; end
    #1 {psel, penable} = 2'b00;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK($sformatf("reg %h", a), e, rd)
  endtask
  task automatic irqchk(input logic e);
    repeat (2) @(posedge ref_clk);
    #1 `CHK("irq", e, irq)
  endtask
  // Reference counter: reload and count on zero, else count down.
  task automatic mstep(input int k);
    repeat (k) if (sel != 2'h0) begin
      if (m_div == 0) begin m_div = m_psc; m_cnt++; end else m_div--;
    end
  endtask
  task automatic ticks(input int k);
    i_rtc_osc_model.pulses(k);
    mstep(k);
  endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    #1 {rst_n, bkp_n} = 2'b11;
    // Bus and backup write access are taken as granted here.
    rchk(RTC_OFF_INTEN, 32'h0);
    rchk(RTC_OFF_CTL, 32'h20);
    rchk(RTC_OFF_DIVL, 32'h0);
    v = $random(seed);
    apb(1'b1, RTC_OFF_INTEN, v);
    rchk(RTC_OFF_INTEN, v & 32'h7);
    apb(1'b1, RTC_OFF_INTEN, 32'h0);
    apb(1'b0, 8'h28, 32'h0);
    `CHK("pslverr", 1'b1, err)
    $display("test reset_regs done");
    apb(1'b1, RTC_OFF_CTL, 32'h10);
    apb(1'b1, RTC_OFF_PSCL, 32'h1);
    apb(1'b1, RTC_OFF_CNTH, 32'hffff);
    apb(1'b1, RTC_OFF_CNTL, 32'hfffe);
    apb(1'b1, RTC_OFF_ALRMH, 32'hffff);
    apb(1'b1, RTC_OFF_ALRML, 32'hffff);
    apb(1'b1, RTC_OFF_CTL, 32'h0);
    rchk(RTC_OFF_CTL, 32'h0);
    i_rtc_osc_model.pulses(2);
    rchk(RTC_OFF_CTL, 32'h08);
    i_rtc_osc_model.pulses(1);
    rchk(RTC_OFF_CTL, 32'h28);
    {m_cnt, m_psc, m_div} = {32'hfffffffe, 32'h1, 32'h1};
    $display("test config done");
    apb(1'b1, RTC_OFF_INTEN, 32'h7);
    apb(1'b1, RTC_OFF_CTL, 32'h0);
    rchk(RTC_OFF_CTL, 32'h20);
    ticks(4);
    rchk(RTC_OFF_CTL, 32'h2f);
    irqchk(1'b1);
    rchk(RTC_OFF_CNTL, m_cnt & 32'hffff);
    rchk(RTC_OFF_CNTH, m_cnt >> 16);
    apb(1'b1, RTC_OFF_CTL, 32'h2e);
    rchk(RTC_OFF_CTL, 32'h2e);
    for (int b = 0; b < 3; b++) begin
      apb(1'b1, RTC_OFF_INTEN, 32'h1 << b);
      irqchk(b != 0);
    end
    apb(1'b1, RTC_OFF_INTEN, 32'h0);
    irqchk(1'b0);
    $display("test flags done");
    @(posedge ref_clk) #1 rst_n = 1'b0;
    @(posedge ref_clk) #1 rst_n = 1'b1;
    rchk(RTC_OFF_INTEN, 32'h0);
    rchk(RTC_OFF_CTL, 32'h26);
    ticks(1);
    rchk(RTC_OFF_CTL, 32'h2e);
    rchk(RTC_OFF_CNTL, m_cnt & 32'hffff);
    rchk(RTC_OFF_DIVL, m_div);
    apb(1'b1, RTC_OFF_CNTL, 32'h5);
    for (int s = 0; s < 3; s++) begin
      sel = 2'(s);
      ticks(1 + ($random(seed) & 3));
      rchk(RTC_OFF_DIVL, m_div);
      rchk(RTC_OFF_CNTL, m_cnt & 32'hffff);
    end
    // Exactly 128 crystal rises per tick, so this run makes two ticks.
    sel = 2'h3;
    repeat (256) begin
      @(posedge ref_clk) #1 hsx = 1'b1;
      @(posedge ref_clk) #1 hsx = 1'b0;
    end
    mstep(2);
    rchk(RTC_OFF_DIVL, m_div);
    rchk(RTC_OFF_CNTL, m_cnt & 32'hffff);
    $display("test sources done");
    finish_test;
  end
endmodule // rtc_core_test
